// ===== verilog/cra_pkg.sv
// package: constants and carrier types for the configuration register access block
package cra_pkg;

    // host i/o port addresses of the address/data window
    localparam logic [15:0] CRA_IO_ADDR_PORT = 16'h0cf8;
    localparam logic [15:0] CRA_IO_DATA_PORT = 16'h0cfc;
    localparam logic [15:0] CRA_IO_PORT_MASK = 16'hfffc;

    // address pointer field layout
    localparam int CRA_EN_BIT = 31;
    localparam int CRA_BUS_LSB = 16;
    localparam int CRA_DEV_LSB = 11;
    localparam int CRA_FUN_LSB = 8;
    localparam int CRA_REG_LSB = 2;
    localparam logic [31:0] CRA_PTR_MASK = 32'h80ff_fffc;
    localparam logic [31:0] CRA_PTR_RESET = 32'h0000_0000;

    // logical device numbers on bus 0
    localparam logic [4:0] CRA_DEV_HOST_HUB = 5'h00;
    localparam logic [4:0] CRA_DEV_GFX_PORT = 5'h01;
    localparam logic [4:0] CRA_DEV_INTEGRATED_GRAPHICS_FUNCTION = 5'h02;
    localparam logic [1:0] CRA_NUM_SETS = 2'h3;

    localparam int CRA_BYTES = 4;
    localparam int CRA_REG_IDX_W = 6;

    // per-bit attribute codes
    typedef enum logic [2:0] {
        CRA_ATTR_RSVD,
        CRA_ATTR_RO,
        CRA_ATTR_RW,
        CRA_ATTR_WRITE_ONE_CLEAR_ATTR,
        CRA_ATTR_WRITE_ONCE_ATTR,
        CRA_ATTR_LOCKABLE
    } cra_attr_type;

    // one host i/o cycle
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cra_req_type;

    // completion of a host cycle
    typedef struct packed {
        logic done;
        logic [31:0] rdata;
    } cra_rsp_type;

endpackage : cra_pkg

// ===== verilog/cra_bit_cell.sv
// one configuration register bit with its access attribute
module cra_bit_cell
    import cra_pkg::*;
#(
    parameter cra_attr_type ATTR = CRA_ATTR_RW,
    parameter logic DEFAULT = 1'b0,
    parameter logic USE_STRAP = 1'b0
) (
    input wire logic clk,
    input wire logic full_rst,
    input wire logic warm_rst,
    input wire logic strap_val,
    input wire logic wr_en,
    input wire logic wr_bit,
    input wire logic lock,
    input wire logic hw_set,
    output logic q
);

    logic q_r;
    logic q_nxt;
    logic once_r;
    logic once_nxt;
    logic dflt;

    assign dflt = USE_STRAP ? strap_val : DEFAULT;
    assign q = q_r;

    always_comb begin
        q_nxt = q_r;
        once_nxt = once_r;
        case (ATTR)
            CRA_ATTR_RW: begin
                if (wr_en) begin
                    q_nxt = wr_bit;
                end
            end
            CRA_ATTR_WRITE_ONE_CLEAR_ATTR: begin
                // event wins over a clear in the same cycle
                if (wr_en && wr_bit) begin
                    q_nxt = 1'b0;
                end
                if (hw_set) begin
                    q_nxt = 1'b1;
                end
            end
            CRA_ATTR_WRITE_ONCE_ATTR: begin
                if (wr_en && !once_r) begin
                    q_nxt = wr_bit;
                    once_nxt = 1'b1;
                end
            end
            CRA_ATTR_LOCKABLE: begin
                if (wr_en && !lock) begin
                    q_nxt = wr_bit;
                end
            end
            CRA_ATTR_RSVD: begin
                q_nxt = 1'b0;
            end
            default: begin
                q_nxt = q_r;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (full_rst) begin
            q_r <= dflt;
            once_r <= 1'b0;
        end else if (warm_rst) begin
            // written-once bits keep their value across warm reset
            if (ATTR != CRA_ATTR_WRITE_ONCE_ATTR) begin
                q_r <= dflt;
            end
        end else begin
            q_r <= q_nxt;
            once_r <= once_nxt;
        end
    end

endmodule : cra_bit_cell

// ===== verilog/cra_config_space.sv
// configuration register space reached through the host i/o address/data window
module cra_config_space
    import cra_pkg::*;
#(
    parameter int REG_IDX_W = CRA_REG_IDX_W,
    parameter logic [7:0] STRAP_BYTE_DEFAULT = 8'hff
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_SRST,
    input wire logic I_RESET_IN_N,
    input wire logic I_POWER_GOOD_IN,
    // strap levels
    input wire logic [7:0] I_STRAP,
    // host i/o cycles
    input wire cra_pkg::cra_req_type I_REQ,
    output cra_pkg::cra_rsp_type O_RSP,
    // live configuration
    output logic [31:0] O_CTRL_WORD,
    output logic O_LOCKED,
    input wire logic I_EVENT,
    output logic [7:0] O_STRAP_LATCHED
);

////////////////////////////////////////////////////////////////////////////////
    import cra_pkg::*;

    localparam int NREG = 4;

    // register 0: control (rw lo, lockable hi), 1: status (w1c / ro),
    // 2: write-once word, 3: strap word (ro, strap default)
    logic full_rst;
    logic warm_rst;
    logic pg_d_r;
    logic [7:0] strap_r;
    logic [31:0] ptr_r;
    logic [31:0] ptr_nxt;
    cra_rsp_type rsp_r;
    cra_rsp_type rsp_nxt;
    logic [31:0] reg_q [NREG];
    logic [NREG-1:0] reg_hit;
    logic [31:0] wmask;
    logic [4:0] dev_f;
    logic [REG_IDX_W-1:0] reg_f;
    logic cfg_hit;
    logic io_addr_sel;
    logic io_data_sel;

    assign full_rst = I_SRST || (!I_RESET_IN_N && !I_POWER_GOOD_IN);
    assign warm_rst = !I_RESET_IN_N && I_POWER_GOOD_IN;

////////////////////////////////////////////////////////////////////////////////
// strap capture

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            // idle-high power good must not look like a fresh edge after reset
            pg_d_r <= 1'b1;
            strap_r <= STRAP_BYTE_DEFAULT;
        end else begin
            pg_d_r <= I_POWER_GOOD_IN;
            if (I_POWER_GOOD_IN && !pg_d_r) begin
                strap_r <= I_STRAP;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// decode

    assign io_addr_sel = (I_REQ.addr & CRA_IO_PORT_MASK) == CRA_IO_ADDR_PORT;
    assign io_data_sel = (I_REQ.addr & CRA_IO_PORT_MASK) == CRA_IO_DATA_PORT;
    assign dev_f = ptr_r[CRA_DEV_LSB +: 5];
    assign reg_f = ptr_r[CRA_REG_LSB +: REG_IDX_W];
    // only the three local sets on bus 0, function 0, decode here
    assign cfg_hit = ptr_r[CRA_EN_BIT] && (ptr_r[CRA_BUS_LSB +: 8] == 8'h00)
        && (ptr_r[CRA_FUN_LSB +: 3] == 3'h0)
        && (dev_f < {3'h0, CRA_NUM_SETS});

    // only the host hub set (device 0) reaches the register window; the other sets read zero and drop writes
    generate
        for (genvar b = 0; b < CRA_BYTES; b++) begin : g_mask
            assign wmask[8*b +: 8] = {8{I_REQ.be[b]}};
        end
    endgenerate

    always_comb begin
        reg_hit = '0;
        for (int i = 0; i < NREG; i++) begin
            reg_hit[i] = I_REQ.valid && I_REQ.write && io_data_sel && cfg_hit
                && (dev_f == CRA_DEV_HOST_HUB)
                && (reg_f == REG_IDX_W'(i));
        end
    end

////////////////////////////////////////////////////////////////////////////////
// register bits

    generate
        for (genvar r = 0; r < NREG; r++) begin : g_reg
            for (genvar k = 0; k < 32; k++) begin : g_bit
                localparam cra_attr_type A =
                    (r == 0) ? ((k < 16) ? CRA_ATTR_RW : CRA_ATTR_LOCKABLE) :
                    (r == 1) ? ((k < 8) ? CRA_ATTR_WRITE_ONE_CLEAR_ATTR :
                                (k == 31) ? CRA_ATTR_RO : CRA_ATTR_RSVD) :
                    (r == 2) ? CRA_ATTR_WRITE_ONCE_ATTR :
                    ((k < 8) ? CRA_ATTR_RO : CRA_ATTR_RSVD);
                cra_bit_cell #(
                    .ATTR(A),
                    .DEFAULT((r == 1 && k == 31) ? 1'b1 : 1'b0),
                    .USE_STRAP((r == 3 && k < 8) ? 1'b1 : 1'b0)
                ) u_bit (
                    .clk(I_SYS_CLK),
                    .full_rst(full_rst),
                    .warm_rst(warm_rst),
                    .strap_val(strap_r[k % 8]),
                    .wr_en(reg_hit[r] && wmask[k]),
                    .wr_bit(I_REQ.wdata[k]),
                    .lock(reg_q[0][0]),
                    .hw_set((r == 1 && k == 0) ? I_EVENT : 1'b0),
                    .q(reg_q[r][k])
                );
            end
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// address pointer and completion

    always_comb begin
        ptr_nxt = ptr_r;
        rsp_nxt.done = 1'b0;
        rsp_nxt.rdata = '0;
        if (I_REQ.valid) begin
            rsp_nxt.done = 1'b1;
            if (io_addr_sel) begin
                // narrow pointer cycles complete but are dropped
                if (I_REQ.write && (I_REQ.be == 4'hf)) begin
                    ptr_nxt = I_REQ.wdata & CRA_PTR_MASK;
                end else if (!I_REQ.write && (I_REQ.be == 4'hf)) begin
                    rsp_nxt.rdata = ptr_r;
                end
            end else if (io_data_sel && !I_REQ.write && cfg_hit
                    && (dev_f == CRA_DEV_HOST_HUB) && (reg_f < REG_IDX_W'(NREG))) begin
                rsp_nxt.rdata = reg_q[reg_f[1:0]] & wmask;
            end else begin
                rsp_nxt.rdata = '0;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (full_rst || warm_rst) begin
            ptr_r <= CRA_PTR_RESET;
            rsp_r <= '0;
            O_CTRL_WORD <= '0;
            O_LOCKED <= 1'b0;
            O_STRAP_LATCHED <= '0;
        end else begin
            ptr_r <= ptr_nxt;
            rsp_r <= rsp_nxt;
            O_CTRL_WORD <= reg_q[0];
            O_LOCKED <= reg_q[0][0];
            O_STRAP_LATCHED <= strap_r;
        end
    end

    assign O_RSP = rsp_r;

endmodule : cra_config_space

// ===== verification/cra_config_space_sva.sv
// checker for the configuration register access block
module cra_config_space_sva
    import cra_pkg::*;
(
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_SRST,
    input wire logic I_RESET_IN_N,
    input wire logic I_POWER_GOOD_IN,
    // straps and host cycles
    input wire logic [7:0] I_STRAP,
    input wire cra_pkg::cra_req_type I_REQ,
    input wire cra_pkg::cra_rsp_type O_RSP,
    // live configuration
    input wire logic [31:0] O_CTRL_WORD,
    input wire logic O_LOCKED,
    input wire logic I_EVENT,
    input wire logic [7:0] O_STRAP_LATCHED
);
    wire logic rst_any = I_SRST || !I_RESET_IN_N;
    wire logic wr_take = I_REQ.valid && I_REQ.write;
    wire logic ptr_hit = I_REQ.valid && I_REQ.addr == CRA_IO_ADDR_PORT && I_REQ.be == 4'hf;
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (rst_any);
    ////////////////////////////////////////////////////////////////////////
    property p_done;
        I_REQ.valid |=> O_RSP.done;
    endproperty
    a_done: assert property (p_done) else $error("cycle not completed");
    property p_no_done;
        !I_REQ.valid |=> !O_RSP.done;
    endproperty
    a_no_done: assert property (p_no_done) else $error("stray completion");
    property p_ptr_narrow;
        I_REQ.valid && !I_REQ.write && (I_REQ.addr & CRA_IO_PORT_MASK) == CRA_IO_ADDR_PORT
            && I_REQ.be != 4'hf |=> O_RSP.rdata == 32'h0;
    endproperty
    a_ptr_narrow: assert property (p_ptr_narrow) else $error("narrow pointer read");
    property p_ptr_back;
        ptr_hit && I_REQ.write ##2 ptr_hit && !I_REQ.write
            |=> O_RSP.rdata == ($past(I_REQ.wdata, 3) & CRA_PTR_MASK);
    endproperty
    a_ptr_back: assert property (p_ptr_back) else $error("pointer readback");
    property p_lane;
        I_REQ.valid && !I_REQ.write && !I_REQ.be[0] |=> O_RSP.rdata[7:0] == 8'h00;
    endproperty
    a_lane: assert property (p_lane) else $error("unselected lane");
    property p_lock_hold;
        O_LOCKED |=> $stable(O_CTRL_WORD[31:16]);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked field moved");
    property p_cause;
        $changed(O_CTRL_WORD) |-> $past(wr_take) || $past(wr_take, 2) || $past(rst_any)
            || $past(rst_any, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("control changed alone");
    property p_rst;
        disable iff (1'b0) I_SRST |=> O_CTRL_WORD == 32'h0 && !O_LOCKED;
    endproperty
    a_rst: assert property (p_rst) else $error("reset default");
endmodule : cra_config_space_sva

bind cra_config_space cra_config_space_sva u_sva (.I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST),
    .I_RESET_IN_N(I_RESET_IN_N), .I_POWER_GOOD_IN(I_POWER_GOOD_IN), .I_STRAP(I_STRAP),
    .I_REQ(I_REQ), .O_RSP(O_RSP), .O_CTRL_WORD(O_CTRL_WORD), .O_LOCKED(O_LOCKED),
    .I_EVENT(I_EVENT), .O_STRAP_LATCHED(O_STRAP_LATCHED));

// ===== verification/cra_host_model.sv
// host processor model issuing i/o cycles
module cra_host_model
    import cra_pkg::*;
(
    input wire logic clk,
    output cra_pkg::cra_req_type req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // one cycle per call; released data inverted so stale values never match
    task automatic cyc(input logic w, input logic [15:0] a, input logic [3:0] be,
        input logic [31:0] d);
        @(negedge clk);
        req <= '{1'b1, w, a, be, d};
        @(negedge clk);
        req <= '{1'b0, ~w, ~a, ~be, ~d};
    endtask : cyc
endmodule : cra_host_model

// ===== verification/config_register_access_rules_tb.sv
// testbench for the configuration register access block
module config_register_access_rules_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cra_pkg::*;
    localparam logic [15:0] ap = CRA_IO_ADDR_PORT;
    localparam logic [15:0] dp = CRA_IO_DATA_PORT;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rst_n = 1'b1;
    logic pg = 1'b1;
    logic evt = 1'b0;
    logic [7:0] strap = 8'h5a;
    cra_req_type req;
    cra_rsp_type rsp;
    logic [31:0] ctrl;
    logic locked;
    logic [7:0] strap_q;
    logic [31:0] r;
    logic [32:0] e;
    logic [32:0] expq[$];
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 32'h029e2a3d;
    always #2.5 clk = ~clk;
    cra_config_space dut (.I_SYS_CLK(clk), .I_SRST(srst), .I_RESET_IN_N(rst_n),
        .I_POWER_GOOD_IN(pg), .I_STRAP(strap), .I_REQ(req), .O_RSP(rsp),
        .O_CTRL_WORD(ctrl), .O_LOCKED(locked), .I_EVENT(evt), .O_STRAP_LATCHED(strap_q));
    cra_host_model host (.clk(clk), .req(req));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        if (expq.size() != 0) errors++;
        if (errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
        expq.push_back({1'b0, 32'h0});
        host.cyc(1'b1, a, be, d);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [3:0] be, input logic [31:0] x);
        expq.push_back({1'b1, x});
        host.cyc(1'b0, a, be, 32'h0);
    endtask : rd
    // completions are matched in issue order
    always @(negedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            stop_test();
        end
        if (rsp.done === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            if (e[32]) chk(rsp.rdata, e[31:0]);
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        srst <= 1'b0;
        wr(ap, 4'hf, 32'h8000_0000);
        wr(dp, 4'hf, 32'h1234_5678);
        rd(dp, 4'hf, 32'h1234_5678);
        wr(dp, 4'h2, 32'h0000_ab00);
        rd(dp, 4'hf, 32'h1234_ab78);
        rd(dp, 4'h4, 32'h0034_0000);
        wr(dp, 4'h1, 32'h0000_0001);
        wr(dp, 4'hc, 32'hffff_0000);
        rd(dp, 4'hf, 32'h1234_ab01);
        wr(dp, 4'h2, 32'h0000_5500);
        rd(dp, 4'hf, 32'h1234_5501);
        chk({31'h0, locked}, 32'h1);
        chk(ctrl, 32'h1234_5501);
        wr(ap, 4'hf, 32'h8000_0004);
        evt <= 1'b1;
        @(negedge clk);
        evt <= 1'b0;
        rd(dp, 4'hf, 32'h8000_0001);
        wr(dp, 4'hf, 32'h7fff_fffe);
        rd(dp, 4'hf, 32'h8000_0001);
        wr(dp, 4'hf, 32'h0000_0001);
        rd(dp, 4'hf, 32'h8000_0000);
        wr(ap, 4'hf, 32'h8000_0008);
        r = $random(seed);
        wr(dp, 4'hf, r);
        wr(dp, 4'hf, ~r);
        rd(dp, 4'hf, r);
        rst_n <= 1'b0;
        repeat (2) @(negedge clk);
        rst_n <= 1'b1;
        wr(ap, 4'hf, 32'h8000_0008);
        rd(dp, 4'hf, r);
        wr(ap, 4'hf, 32'h8000_0000);
        rd(dp, 4'hf, 32'h0);
        rst_n <= 1'b0;
        pg <= 1'b0;
        strap <= 8'($random(seed));
        @(negedge clk);
        pg <= 1'b1;
        repeat (2) @(negedge clk);
        rst_n <= 1'b1;
        wr(ap, 4'hf, 32'h8000_000c);
        rd(dp, 4'hf, {24'h0, strap});
        chk({24'h0, strap_q}, {24'h0, strap});
        wr(ap, 4'hf, 32'h8000_0008);
        wr(dp, 4'hf, ~r);
        rd(dp, 4'hf, ~r);
        wr(ap, 4'hf, 32'h8000_0014);
        wr(dp, 4'hf, 32'hffff_ffff);
        rd(dp, 4'hf, 32'h0);
        rd(dp, 4'h1, 32'h0);
        rd(dp, 4'h3, 32'h0);
        wr(ap, 4'hf, 32'h8000_0800);
        rd(ap, 4'hf, 32'h8000_0800);
        rd(dp, 4'hf, 32'h0);
        wr(ap, 4'h1, 32'h0000_00ff);
        rd(ap, 4'h1, 32'h0);
        rd(ap, 4'hf, 32'h8000_0800);
        wr(ap, 4'hf, 32'h0000_0000);
        rd(dp, 4'hf, 32'h0);
        repeat (4) @(negedge clk);
        stop_test();
    end
endmodule : config_register_access_rules_tb
